// ---- design/fspm_consts.svh ----
// Purpose: Constants for the flash self-program map block.
// Assumes: Word addresses; fuse pair codes as raw bits.
// Notes:   Included by the package and design modules.
`ifndef FSPM_CONSTS_SVH
`define FSPM_CONSTS_SVH

`define FSPM_CLK_HZ          50000000
`define FSPM_WR_TIME_US      4100
`define FSPM_WR_MIN_US       3700
`define FSPM_WR_MAX_US       4500

`define FSPM_BOOT4K_11       16'h0f80
`define FSPM_BOOT4K_10       16'h0f00
`define FSPM_BOOT4K_01       16'h0e00
`define FSPM_BOOT4K_00       16'h0c00
`define FSPM_BOOT8K_11       16'h1f80
`define FSPM_BOOT8K_10       16'h1f00
`define FSPM_BOOT8K_01       16'h1e00
`define FSPM_BOOT8K_00       16'h1c00

`define FSPM_NRWW4K_START    16'h0c00
`define FSPM_NRWW8K_START    16'h1c00

`define FSPM_PC4K_TOP        4'hb
`define FSPM_PC8K_TOP        4'hc
`define FSPM_ZPG4K_LSB       6
`define FSPM_ZPG8K_LSB       7
`define FSPM_WORD4K_MASK     16'h003e
`define FSPM_WORD8K_MASK     16'h007e
`define FSPM_PC4K_MASK       16'h0fff
`define FSPM_PC8K_MASK       16'h1fff

`endif

// ---- design/fspm_pkg.sv ----
// Purpose: Types for the flash self-program map block.
// Assumes: Constants come from fspm_consts.svh.
// Notes:   Carries the command and map result structs.
`default_nettype none
`include "fspm_consts.svh"
package fspm_pkg;
   typedef enum logic [1:0] {
      FSPM_IDLE = 2'b00,
      FSPM_BUSY = 2'b01,
      FSPM_DONE = 2'b10
   } fspm_state_t;

   typedef struct packed {
      logic        erase;
      logic        write;
      logic        lock;
      logic        reenable;
   } fspm_cmd_t;

   typedef struct packed {
      logic [15:0] boot_start;
      logic [15:0] app_end;
      logic [15:0] stalled_read_region_start;
   } fspm_map_t;

   typedef struct packed {
      logic [6:0]  page;
      logic [5:0]  word;
      logic        byte_sel;
      logic [15:0] pc;
   } fspm_addr_t;
endpackage
`default_nettype wire

// ---- design/fspm_addr_map.sv ----
// Purpose: Decodes boot section, region limit and Z pointer split.
// Assumes: i_is_8k picks the 8K-word layout.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "fspm_consts.svh"
module fspm_addr_map
   import fspm_pkg::*;
(
   // Configuration
   input  wire logic        i_is_8k,
   input  wire logic [1:0]  i_boot_size,
   // Pointer
   input  wire logic [15:0] i_zptr,
   // Results
   output var fspm_map_t    o_map,
   output var fspm_addr_t   o_addr
);
   function automatic logic [15:0] boot_start(input logic big, input logic [1:0] sz);
      logic [15:0] r;
      r = 16'h0000;
      unique case (sz)
         2'b11: r = big ? `FSPM_BOOT8K_11 : `FSPM_BOOT4K_11;
         2'b10: r = big ? `FSPM_BOOT8K_10 : `FSPM_BOOT4K_10;
         2'b01: r = big ? `FSPM_BOOT8K_01 : `FSPM_BOOT4K_01;
         2'b00: r = big ? `FSPM_BOOT8K_00 : `FSPM_BOOT4K_00;
      endcase
      return r;
   endfunction

   logic [15:0] pc;

   always_comb begin
      o_map.boot_start = boot_start(i_is_8k, i_boot_size);
      o_map.app_end    = o_map.boot_start - 16'h0001;
      o_map.stalled_read_region_start = i_is_8k ? `FSPM_NRWW8K_START : `FSPM_NRWW4K_START;
      // Top pointer bits dropped by the mask
      pc = (i_zptr >> 1) & (i_is_8k ? `FSPM_PC8K_MASK : `FSPM_PC4K_MASK);
      o_addr.pc = pc;
      if (i_is_8k) begin
         o_addr.page = i_zptr[13:`FSPM_ZPG8K_LSB];
         o_addr.word = i_zptr[6:1];
      end else begin
         o_addr.page = i_zptr[12:`FSPM_ZPG4K_LSB];
         o_addr.word = {1'b0, i_zptr[5:1]};
      end
      o_addr.byte_sel = i_zptr[0];
   end
endmodule
`default_nettype wire

// ---- design/fspm_top.sv ----
// Purpose: Self-program sequencer: region blocking, busy flag and write timing.
// Assumes: Commands are one-cycle strobes from the CPU core, synchronous to i_clk_sys.
// Notes:   Write time counter is a parameter so simulation can shorten it.
`timescale 1ns/1ps
`default_nettype none
`include "fspm_consts.svh"
module fspm_top
   import fspm_pkg::*;
#(
   parameter int unsigned WR_CYCLES = (`FSPM_WR_TIME_US * (`FSPM_CLK_HZ / 1000000))
)(
   // Clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_nrst,
   // Configuration
   input  wire logic        i_is_8k,
   input  wire logic        i_boot_size_sel_hi,
   input  wire logic        i_boot_size_sel_lo,
   // CPU command
   input  wire logic        i_self_program_cmd_enable,
   input  wire fspm_cmd_t   i_cmd,
   input  wire logic        i_eeprom_write_active,
   input  wire logic [15:0] i_zptr,
   // CPU fetch
   input  wire logic [15:0] i_fetch_addr,
   // Status and map
   output logic             o_busy,
   output logic             o_concurrent_region_busy_flag,
   output logic             o_fetch_allowed,
   output logic             o_cmd_done,
   output var fspm_map_t    o_map,
   output var fspm_addr_t   o_addr,
   output logic [6:0]       o_op_page
);
   localparam int unsigned MIN_CYC = (`FSPM_WR_MIN_US * (`FSPM_CLK_HZ / 1000000));
   localparam int unsigned MAX_CYC = (`FSPM_WR_MAX_US * (`FSPM_CLK_HZ / 1000000));

   // Counter is 24 bits wide and needs at least one cycle
   if (WR_CYCLES < 1 || WR_CYCLES > 32'h00ffffff) begin : g_wr_range
      $error("WR_CYCLES out of range");
   end

   fspm_state_t state_q;
   logic [23:0] cnt_q;
   logic        rww_busy_q;
   logic        done_q;
   logic [6:0]  page_q;
   logic        start;
   logic        in_stalled_read_region;
   fspm_addr_t  addr_w;

   fspm_addr_map u_map (
      .i_is_8k     (i_is_8k),
      .i_boot_size ({i_boot_size_sel_hi, i_boot_size_sel_lo}),
      .i_zptr      (i_zptr),
      .o_map       (o_map),
      .o_addr      (addr_w)
   );

   assign o_addr = addr_w;

   // Erase, write and lock strobes arriving while busy or during an EEPROM write are dropped
   assign start = (state_q == FSPM_IDLE) && i_self_program_cmd_enable && !i_eeprom_write_active
                  && (i_cmd.erase || i_cmd.write || i_cmd.lock);

   // Operation timer
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         state_q <= FSPM_IDLE;
         cnt_q   <= 24'h000000;
      end else begin
         unique case (state_q)
            FSPM_IDLE: begin
               if (start) begin
                  state_q <= FSPM_BUSY;
                  cnt_q   <= WR_CYCLES[23:0] - 24'h000001;
               end
            end
            FSPM_BUSY: begin
               if (cnt_q == 24'h000000) begin
                  state_q <= FSPM_DONE;
               end else begin
                  cnt_q <= cnt_q - 24'h000001;
               end
            end
            FSPM_DONE: begin
               state_q <= FSPM_IDLE;
            end
            default: begin
               state_q <= FSPM_IDLE;
            end
         endcase
      end
   end

   // Latched page of the running operation
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         page_q <= 7'h00;
      end else if (start) begin
         page_q <= addr_w.page;
      end
   end

   // Busy flag: set by erase or write, cleared by re-enable when idle; set wins
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         rww_busy_q <= 1'b0;
      end else if (start && (i_cmd.erase || i_cmd.write)) begin
         rww_busy_q <= 1'b1;
      end else if (state_q == FSPM_IDLE && i_self_program_cmd_enable && i_cmd.reenable) begin
         rww_busy_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         done_q <= 1'b0;
      end else begin
         done_q <= (state_q == FSPM_BUSY) && (cnt_q == 24'h000000);
      end
   end

   assign in_stalled_read_region = ((i_fetch_addr & (i_is_8k ? `FSPM_PC8K_MASK : `FSPM_PC4K_MASK))
                     >= o_map.stalled_read_region_start);
   assign o_fetch_allowed = in_stalled_read_region || !rww_busy_q;
   assign o_busy = (state_q != FSPM_IDLE);
   assign o_concurrent_region_busy_flag = rww_busy_q;
   assign o_cmd_done = done_q;
   assign o_op_page = page_q;

   // Timing window check on each completed operation when WR_CYCLES is left at its default
   logic [23:0] dur_q;
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         dur_q <= 24'h000000;
      end else if (start) begin
         dur_q <= 24'h000001;
      end else if (state_q != FSPM_IDLE) begin
         dur_q <= dur_q + 24'h000001;
      end
   end

   a_write_time_window: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      ($rose(done_q) && WR_CYCLES == (`FSPM_WR_TIME_US * (`FSPM_CLK_HZ / 1000000)))
      |-> (dur_q >= MIN_CYC[23:0] && dur_q <= MAX_CYC[23:0]))
      else $error("flash write time outside window");

   a_busy_set_start: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (start && (i_cmd.erase || i_cmd.write)) |=> o_concurrent_region_busy_flag)
      else $error("busy flag not set by erase or write");

   a_busy_holds_op: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (state_q == FSPM_BUSY && rww_busy_q) |=> rww_busy_q)
      else $error("busy flag dropped during operation");

   a_block_rww_read: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (rww_busy_q && i_fetch_addr[12:0] < 13'h0c00 && !i_is_8k) |-> !o_fetch_allowed)
      else $error("concurrent region readable while busy");

   a_stalled_read_region_readable: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (!i_is_8k && i_fetch_addr[11:10] == 2'b11) |-> o_fetch_allowed)
      else $error("stalled region fetch blocked");

   a_boot_start_8k: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (i_is_8k && !i_boot_size_sel_hi && !i_boot_size_sel_lo) |-> (o_map.boot_start == 16'h1c00
      && o_map.app_end == 16'h1bff))
      else $error("8K boot start wrong");

   a_boot_start_4k: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (!i_is_8k && i_boot_size_sel_hi && i_boot_size_sel_lo) |-> o_map.boot_start == 16'h0f80)
      else $error("4K boot start wrong");

   a_page_split_8k: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      i_is_8k |-> (o_addr.page == i_zptr[13:7] && o_addr.word == i_zptr[6:1]))
      else $error("8K pointer split wrong");

   a_page_split_4k: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      !i_is_8k |-> (o_addr.page == i_zptr[12:6] && o_addr.pc[15:12] == 4'h0))
      else $error("4K pointer split wrong");

   a_top_bits_ignored: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      i_is_8k |-> o_addr.pc[15:13] == 3'b000)
      else $error("high pointer bits leak into pc");

   a_no_start_ee: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (state_q == FSPM_IDLE && i_eeprom_write_active) |=> state_q == FSPM_IDLE)
      else $error("operation started during eeprom write");

   a_reset_clears: assert property (@(posedge i_clk_sys)
      !i_nrst |=> (state_q == FSPM_IDLE && !o_concurrent_region_busy_flag && !o_cmd_done && o_op_page == 7'h00))
      else $error("state not cleared by reset");

   a_busy_after_start: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      start |=> (o_busy && state_q == FSPM_BUSY))
      else $error("operation did not start");

   a_count_load: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      start |=> cnt_q == WR_CYCLES[23:0] - 24'h000001)
      else $error("write timer loaded wrong");

   a_count_down: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (state_q == FSPM_BUSY && cnt_q != 24'h000000)
      |=> (state_q == FSPM_BUSY && cnt_q == $past(cnt_q) - 24'h000001))
      else $error("write timer did not count down");

   a_busy_to_done: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (state_q == FSPM_BUSY && cnt_q == 24'h000000) |=> (state_q == FSPM_DONE && o_cmd_done))
      else $error("operation did not finish at timer end");

   a_done_to_idle: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      state_q == FSPM_DONE |=> (state_q == FSPM_IDLE && !o_busy))
      else $error("done state did not return to idle");

   a_done_one_cycle: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      o_cmd_done |=> !o_cmd_done)
      else $error("done pulse longer than one cycle");

   a_done_in_done: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      o_cmd_done |-> state_q == FSPM_DONE)
      else $error("done pulse outside done state");

   a_op_length: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      $rose(done_q) |-> dur_q == WR_CYCLES[23:0] + 24'h000001)
      else $error("operation length differs from timer setting");

   a_page_held_busy: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (state_q != FSPM_IDLE) |=> $stable(o_op_page))
      else $error("operation page changed while busy");

   a_page_latch: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      start |=> o_op_page == $past(addr_w.page))
      else $error("operation page not latched at start");

   a_lock_no_flag: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (start && !i_cmd.erase && !i_cmd.write && !rww_busy_q) |=> !rww_busy_q)
      else $error("lock write blocked concurrent region");

   a_reenable_clears: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (state_q == FSPM_IDLE && i_self_program_cmd_enable && i_cmd.reenable && !i_cmd.erase && !i_cmd.write)
      |=> !rww_busy_q)
      else $error("re-enable did not clear busy flag");

   a_flag_kept_busy: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (state_q != FSPM_IDLE && rww_busy_q) |=> rww_busy_q)
      else $error("busy flag dropped before idle");

   a_flag_rise_cause: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      $rose(rww_busy_q) |-> $past(start))
      else $error("busy flag set without a command");

   a_flag_fall_cause: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      $fell(rww_busy_q) |-> ($past(i_cmd.reenable) && $past(i_self_program_cmd_enable)))
      else $error("busy flag cleared without re-enable");

   a_fetch_open_clear: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      !rww_busy_q |-> o_fetch_allowed)
      else $error("fetch blocked with busy flag clear");

   a_block_rww_8k: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (rww_busy_q && i_is_8k && i_fetch_addr[12:0] < `FSPM_NRWW8K_START) |-> !o_fetch_allowed)
      else $error("8K concurrent region readable while busy");

   a_stalled_read_region_readable_8k: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (i_is_8k && i_fetch_addr[12:10] == 3'b111) |-> o_fetch_allowed)
      else $error("8K stalled region fetch blocked");

   a_boot_4k_256: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (!i_is_8k && i_boot_size_sel_hi && !i_boot_size_sel_lo)
      |-> (o_map.boot_start == `FSPM_BOOT4K_10 && o_map.app_end == `FSPM_BOOT4K_10 - 16'h0001))
      else $error("4K 256-word boot section wrong");

   a_boot_4k_512: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (!i_is_8k && !i_boot_size_sel_hi && i_boot_size_sel_lo)
      |-> (o_map.boot_start == `FSPM_BOOT4K_01 && o_map.app_end == `FSPM_BOOT4K_01 - 16'h0001))
      else $error("4K 512-word boot section wrong");

   a_boot_4k_1k: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (!i_is_8k && !i_boot_size_sel_hi && !i_boot_size_sel_lo)
      |-> (o_map.boot_start == `FSPM_BOOT4K_00 && o_map.app_end == `FSPM_BOOT4K_00 - 16'h0001))
      else $error("4K 1024-word boot section wrong");

   a_boot_8k_128: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (i_is_8k && i_boot_size_sel_hi && i_boot_size_sel_lo)
      |-> (o_map.boot_start == `FSPM_BOOT8K_11 && o_map.app_end == `FSPM_BOOT8K_11 - 16'h0001))
      else $error("8K 128-word boot section wrong");

   a_boot_8k_256: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (i_is_8k && i_boot_size_sel_hi && !i_boot_size_sel_lo)
      |-> (o_map.boot_start == `FSPM_BOOT8K_10 && o_map.app_end == `FSPM_BOOT8K_10 - 16'h0001))
      else $error("8K 256-word boot section wrong");

   a_boot_8k_512: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (i_is_8k && !i_boot_size_sel_hi && i_boot_size_sel_lo)
      |-> (o_map.boot_start == `FSPM_BOOT8K_01 && o_map.app_end == `FSPM_BOOT8K_01 - 16'h0001))
      else $error("8K 512-word boot section wrong");

   a_stalled_read_region_start_4k: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      !i_is_8k |-> o_map.stalled_read_region_start == `FSPM_NRWW4K_START)
      else $error("4K region limit wrong");

   a_stalled_read_region_start_8k: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      i_is_8k |-> o_map.stalled_read_region_start == `FSPM_NRWW8K_START)
      else $error("8K region limit wrong");

   a_word_4k: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      !i_is_8k |-> o_addr.word == {1'b0, i_zptr[5:1]})
      else $error("4K word select wrong");

   a_byte_select: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      o_addr.byte_sel == i_zptr[0])
      else $error("byte select wrong");

   a_pc_4k: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      !i_is_8k |-> o_addr.pc == {4'h0, i_zptr[12:1]})
      else $error("4K program counter map wrong");

   a_pc_8k: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      i_is_8k |-> o_addr.pc == {3'b000, i_zptr[13:1]})
      else $error("8K program counter map wrong");

   a_no_start_disabled: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (state_q == FSPM_IDLE && !i_self_program_cmd_enable) |=> state_q == FSPM_IDLE)
      else $error("operation started without enable");
endmodule
`default_nettype wire

// ---- verif/fspm_cpu_model.sv ----
// Purpose: CPU core model issuing self-program commands.
// Assumes: Drives at falling edges; one strobe cycle per command.
// Notes:   Can hold the EEPROM-busy line high across a strobe.
`timescale 1ns/1ps
`default_nettype none
module fspm_cpu_model
   import fspm_pkg::*;
(
   // Clock and status
   input  wire logic        i_clk_sys,
   input  wire logic        i_busy,
   input  wire logic        i_is_8k,
   // Command side
   output var fspm_cmd_t    o_cmd,
   output logic             o_enable,
   output logic             o_eeprom_active,
   output logic [15:0]      o_zptr
);
   initial begin
      o_cmd = '0;
      o_enable = 1'b0;
      o_eeprom_active = 1'b0;
      o_zptr = 16'h0000;
   end
   // Loads use the full pointer, bit 0 picks the byte
   task automatic point(input logic [15:0] z);
      o_zptr = z;
   endtask
   // Waits for idle, then strobes for one cycle
   task automatic issue(input fspm_cmd_t c, input logic [15:0] z, input logic ee);
      int n;
      n = 0;
      // A page write has the word bits of the pointer cleared
      if (c.write) begin
         z[5:1] = 5'h00;
         if (i_is_8k) begin
            z[6] = 1'b0;
         end
      end
      while (i_busy !== 1'b0 && n < 1000) begin
         @(negedge i_clk_sys);
         n++;
      end
      o_eeprom_active = ee;
      o_zptr = {z[15:1], 1'b0};
      o_cmd = c;
      o_enable = 1'b1;
      @(negedge i_clk_sys);
      o_enable = 1'b0;
      o_cmd = '0;
      o_eeprom_active = 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- verif/fspm_top_tb.sv ----
// Purpose: Self-checking bench for the self-program sequencer.
// Assumes: Write time shortened to WR cycles.
// Notes:   Inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module fspm_top_tb;
   import fspm_pkg::*;
   localparam int WR = 8;
   logic        i_clk_sys;
   logic        i_nrst;
   logic        i_is_8k;
   logic        hi;
   logic        lo;
   logic [15:0] fetch;
   logic        en;
   logic        ee;
   logic [15:0] zptr;
   fspm_cmd_t   cmd;
   logic        busy;
   logic        flag;
   logic        fa;
   logic        done;
   fspm_map_t   map;
   fspm_addr_t  addr;
   logic [6:0]  op_page;
   int          miscompares = 0;
   int          n_tests = 0;
   int          cyc = 0;
   logic [15:0] st [8] = '{16'h0c00, 16'h0e00, 16'h0f00, 16'h0f80, 16'h1c00, 16'h1e00, 16'h1f00, 16'h1f80};

   fspm_top #(.WR_CYCLES(WR)) fspm_top_inst (
      .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_is_8k(i_is_8k),
      .i_boot_size_sel_hi(hi), .i_boot_size_sel_lo(lo),
      .i_self_program_cmd_enable(en), .i_cmd(cmd), .i_eeprom_write_active(ee),
      .i_zptr(zptr), .i_fetch_addr(fetch), .o_busy(busy),
      .o_concurrent_region_busy_flag(flag), .o_fetch_allowed(fa), .o_cmd_done(done),
      .o_map(map), .o_addr(addr), .o_op_page(op_page));

   fspm_cpu_model fspm_cpu_model_inst (
      .i_clk_sys(i_clk_sys), .i_busy(busy), .i_is_8k(i_is_8k), .o_cmd(cmd), .o_enable(en),
      .o_eeprom_active(ee), .o_zptr(zptr));

   initial begin
      i_clk_sys = 1'b0;
      forever #10 i_clk_sys = ~i_clk_sys;
   end

   task automatic close_out();
      if (miscompares == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc > 3000) begin
         miscompares++;
         close_out();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic t_map();
      for (int k = 0; k < 8; k++) begin
         @(negedge i_clk_sys);
         {i_is_8k, hi, lo} = k[2:0];
         #1;
         chk(map.boot_start, st[k]);
         chk(map.app_end, st[k] - 16'h0001);
         chk(map.stalled_read_region_start, k[2] ? 16'h1c00 : 16'h0c00);
      end
   endtask

   task automatic t_addr(input logic s, input logic [15:0] z);
      @(negedge i_clk_sys);
      i_is_8k = s;
      fspm_cpu_model_inst.point(z);
      #1;
      chk(addr.page, s ? z[13:7] : z[12:6]);
      chk(addr.word, s ? z[6:1] : {1'b0, z[5:1]});
      chk(addr.byte_sel, z[0]);
      chk(addr.pc, {3'b000, s & z[13], z[12:1]});
   endtask

   // One timed operation, then the re-enable strobe
   task automatic t_op(input fspm_cmd_t c, input logic [15:0] z, input logic s);
      @(negedge i_clk_sys);
      i_is_8k = s;
      fspm_cpu_model_inst.issue(c, z, 1'b0);
      chk(busy, 1'b1);
      chk(op_page, s ? z[13:7] : z[12:6]);
      chk(flag, !c.lock);
      fetch = 16'hfbff;
      #1 chk(fa, c.lock);
      fetch = 16'hfc00;
      #1 chk(fa, 1'b1);
      repeat (WR - 1) @(negedge i_clk_sys);
      chk(done, 1'b0);
      chk(busy, 1'b1);
      @(negedge i_clk_sys);
      chk(done, 1'b1);
      chk(busy, 1'b1);
      @(negedge i_clk_sys);
      chk(done, 1'b0);
      chk(busy, 1'b0);
      chk(flag, !c.lock);
      fspm_cpu_model_inst.issue(4'b0001, z, 1'b0);
      chk(flag, 1'b0);
      fetch = 16'hfbff;
      #1 chk(fa, 1'b1);
   endtask

   task automatic t_refuse();
      @(negedge i_clk_sys);
      fspm_cpu_model_inst.issue(4'b0100, 16'h0040, 1'b1);
      repeat (2) begin
         chk(busy, 1'b0);
         chk(flag, 1'b0);
         @(negedge i_clk_sys);
      end
   endtask

   initial begin
      i_nrst = 1'b0;
      i_is_8k = 1'b0;
      hi = 1'b1;
      lo = 1'b1;
      fetch = 16'h0000;
      repeat (10) @(negedge i_clk_sys);
      chk({busy, flag, done, fa}, 16'h0001);
      i_nrst = 1'b1;
      t_map();
      t_addr(1'b0, 16'hffff);
      t_addr(1'b1, 16'hffff);
      t_addr(1'b0, 16'h2a55);
      t_addr(1'b1, 16'hd5aa);
      t_op(4'b0100, 16'h0bc0, 1'b0);
      t_op(4'b1000, 16'h1b80, 1'b1);
      t_op(4'b0010, 16'h0000, 1'b0);
      t_refuse();
      close_out();
   end
endmodule
`default_nettype wire
